// >>> rtl/iar_pkg.sv
// package for the two-wire address recognition block
// Functional notes
// - first seven bits after a start form the slave address
// - slave detects start, compares seven address bits with own address, selects on match
// - selected slave stays selected until a new start or a stop
// - no transfer-done interrupt unless byte is own address or extension code; the code also pulses it when the master address send ends
// - address and direction bit loaded together as one byte, then shifted out
// - received address byte is stored into the shift register for software; the code stores it only on own address or extension code
// - the seven address bits sit in the upper seven bits of the byte
// - direction bit is 0 for master write, 1 for master read
package iar_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] EXT_CODE = 4'hf;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned SCL_HALF_NS = 5000;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [15:0] SCL_HALF_CNT = SCL_HALF_CYC[15:0];

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic dir;
  } iar_addr_byte_type;

  typedef struct packed {
    logic selected;
    logic dir;
    logic ext;
  } iar_slave_stat_type;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_LOW, M_HIGH, M_ACK_LOW, M_ACK_HIGH, M_DONE
  } iar_mst_state_type;
endpackage

// >>> rtl/iar_slave_link.sv
// link-clock slave receiver: start/stop, address shift and match
`timescale 1ns/1ps
`default_nettype none
module iar_slave_link
  import iar_pkg::*;
(
  input wire logic i_scl_clk,
  input wire logic i_rst_n,
  input wire logic i_sda,
  input wire logic [ADDR_W-1:0] i_own_addr,
  output logic o_sda_oe,
  output logic [BYTE_W-1:0] o_rx_byte,
  output iar_slave_stat_type o_stat,
  output logic o_hit_tgl,
  output logic o_bus_busy
);
  // start/stop seen as sda edges while scl high; scl is this domain's clock so
  // sda edges clock the start and stop toggle flops to catch edges inside the high phase
  logic sda_hi_ff;
  logic start_tgl_ff;
  logic stop_tgl_ff;
  logic start_seen_ff;
  logic stop_seen_ff;
  logic [3:0] cnt_ff;
  logic [BYTE_W-1:0] sh_ff;
  logic addr_phase_ff;
  logic sel_ff;
  logic frame_ff;

  always_ff @(negedge i_sda or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_tgl_ff <= 1'b0;
    end else if (i_scl_clk) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  always_ff @(posedge i_sda or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_tgl_ff <= 1'b0;
    end else if (i_scl_clk) begin
      // copy, not toggle: the bus is free whenever both marks agree,
      // so a stop is seen even though scl then stands still
      stop_tgl_ff <= start_tgl_ff;
    end
  end

  always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_seen_ff <= 1'b0;
      stop_seen_ff <= 1'b0;
      sda_hi_ff <= 1'b1;
    end else begin
      start_seen_ff <= start_tgl_ff;
      stop_seen_ff <= stop_tgl_ff;
      sda_hi_ff <= i_sda;
    end
  end

  wire new_start = start_seen_ff != start_tgl_ff;
  wire new_stop = stop_seen_ff != stop_tgl_ff;
  wire [BYTE_W-1:0] nxt_sh = {sh_ff[BYTE_W-2:0], i_sda};
  wire addr_match = nxt_sh[BYTE_W-1:1] == i_own_addr;
  wire ext_match = nxt_sh[BYTE_W-1:BYTE_W-4] == EXT_CODE;
  assign o_bus_busy = start_tgl_ff != stop_tgl_ff;

  always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 4'h0;
      sh_ff <= '0;
      addr_phase_ff <= 1'b0;
      sel_ff <= 1'b0;
      o_rx_byte <= '0;
      o_stat <= '0;
      o_hit_tgl <= 1'b0;
      frame_ff <= 1'b0;
    end else if (new_start) begin
      // first bit after start is address msb
      cnt_ff <= 4'h1;
      sh_ff <= {{(BYTE_W-1){1'b0}}, i_sda};
      addr_phase_ff <= 1'b1;
      sel_ff <= 1'b0;
      o_stat <= '0;
      frame_ff <= 1'b1;
    end else if (new_stop) begin
      cnt_ff <= 4'h0;
      addr_phase_ff <= 1'b0;
      sel_ff <= 1'b0;
      o_stat <= '0;
      frame_ff <= 1'b0;
    end else if (frame_ff) begin
      if (cnt_ff == BIT_ACK) begin
        cnt_ff <= 4'h0;
      end else begin
        sh_ff <= nxt_sh;
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff == BIT_LAST && addr_phase_ff) begin
          addr_phase_ff <= 1'b0;
          o_rx_byte <= nxt_sh;
          if (addr_match || ext_match) begin
            sel_ff <= addr_match;
            o_stat <= '{selected: addr_match, dir: nxt_sh[0], ext: ext_match};
            o_hit_tgl <= ~o_hit_tgl;
          end
        end
      end
    end
  end

  // ack driven low during ninth clock after a matching address
  always_ff @(negedge i_scl_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sda_oe <= 1'b0;
    end else begin
      o_sda_oe <= sel_ff && cnt_ff == BIT_ACK && !addr_phase_ff;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/iar_top.sv
// two-wire address phase: master address send and slave address recognition
`timescale 1ns/1ps
`default_nettype none
module iar_top
  import iar_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_scl_link_clk,
  input wire logic i_sda,
  input wire logic i_scl,
  input wire logic [ADDR_W-1:0] i_own_slave_address_reg,
  input wire logic i_send_req,
  input wire logic [ADDR_W-1:0] i_send_addr,
  input wire logic i_send_dir,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic [BYTE_W-1:0] o_serial_shift_reg,
  output logic o_selected,
  output logic o_dir_read,
  output logic o_ext_code,
  output logic o_transfer_done_irq,
  output logic o_mst_busy,
  output logic o_mst_acked
);
  logic [1:0] rst_sync_ff;
  wire rst_n = rst_sync_ff[1];
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // link clock stands still while the bus idles, so flops could never release
  // its reset; release there is safe because no link edge comes near it
  logic slv_sda_oe;
  logic [BYTE_W-1:0] slv_rx_byte;
  iar_slave_stat_type slv_stat;
  logic slv_hit_tgl;
  logic slv_busy;

  iar_slave_link u_slave (
    .i_scl_clk(i_scl_link_clk),
    .i_rst_n(i_arst_n),
    .i_sda(i_sda),
    .i_own_addr(i_own_slave_address_reg),
    .o_sda_oe(slv_sda_oe),
    .o_rx_byte(slv_rx_byte),
    .o_stat(slv_stat),
    .o_hit_tgl(slv_hit_tgl),
    .o_bus_busy(slv_busy)
  );

  // hit event crosses as toggle; byte and status are stable by then
  logic [2:0] hit_sync_ff;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_sync_ff <= 3'b000;
    end else begin
      hit_sync_ff <= {hit_sync_ff[1:0], slv_hit_tgl};
    end
  end
  wire slv_hit = hit_sync_ff[2] ^ hit_sync_ff[1];

  // stop/start level and sda/scl pins through three flops
  logic [2:0] busy_sync_ff;
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_sync_ff <= 3'b000;
      scl_sync_ff <= 3'b111;
      sda_sync_ff <= 3'b111;
    end else begin
      busy_sync_ff <= {busy_sync_ff[1:0], slv_busy};
      scl_sync_ff <= {scl_sync_ff[1:0], i_scl};
      sda_sync_ff <= {sda_sync_ff[1:0], i_sda};
    end
  end
  wire slv_busy_s = busy_sync_ff[2] & busy_sync_ff[1];
  wire scl_hi = scl_sync_ff[2] & scl_sync_ff[1];
  wire sda_hi = sda_sync_ff[2] & sda_sync_ff[1];

  // master address sender
  iar_mst_state_type st_ff;
  iar_mst_state_type nxt_st;
  logic [BYTE_W-1:0] tx_sh_ff;
  logic [3:0] bit_ff;
  logic [15:0] tmr_ff;
  logic acked_ff;
  wire tmr_done = tmr_ff == SCL_HALF_CNT;
  wire last_bit = bit_ff == BIT_LAST;
  iar_addr_byte_type load_byte;
  assign load_byte = '{addr: i_send_addr, dir: i_send_dir};

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      M_IDLE: if (i_send_req && !slv_busy_s) nxt_st = M_START;
      M_START: if (tmr_done) nxt_st = M_LOW;
      M_LOW: if (tmr_done) nxt_st = M_HIGH;
      M_HIGH: if (tmr_done && scl_hi) nxt_st = last_bit ? M_ACK_LOW : M_LOW;
      M_ACK_LOW: if (tmr_done) nxt_st = M_ACK_HIGH;
      M_ACK_HIGH: if (tmr_done && scl_hi) nxt_st = M_DONE;
      M_DONE: nxt_st = M_IDLE;
      default: nxt_st = M_IDLE;
    endcase
  end

  wire st_change = nxt_st != st_ff;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= M_IDLE;
      tmr_ff <= '0;
      bit_ff <= '0;
      tx_sh_ff <= '0;
      acked_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      // scl stretching by slave holds the timer at zero in M_HIGH, not in M_ACK_HIGH
      tmr_ff <= (st_change || (st_ff == M_HIGH && !scl_hi)) ? '0 : tmr_ff + 16'h0001;
      if (st_ff == M_IDLE && nxt_st == M_START) begin
        tx_sh_ff <= load_byte;
        bit_ff <= '0;
      end else if (st_ff == M_HIGH && nxt_st == M_LOW) begin
        tx_sh_ff <= {tx_sh_ff[BYTE_W-2:0], 1'b0};
        bit_ff <= bit_ff + 4'h1;
      end
      if (st_ff == M_ACK_HIGH && tmr_done && scl_hi) begin
        acked_ff <= !sda_hi;
      end
    end
  end

  wire mst_active = st_ff != M_IDLE && st_ff != M_DONE;
  // sda holds for the first low cycle so it never moves with the scl fall,
  // which the bus would read as a start or stop
  wire sda_hold = (st_ff == M_LOW || st_ff == M_ACK_LOW) && tmr_ff == 16'h0000;
  wire nxt_sda_oe = sda_hold ? o_sda_oe :
                    ((st_ff == M_START) ||
                     ((st_ff == M_LOW || st_ff == M_HIGH) && !tx_sh_ff[BYTE_W-1]) ||
                     slv_sda_oe);
  wire nxt_scl_oe = mst_active && st_ff != M_START && st_ff != M_HIGH && st_ff != M_ACK_HIGH;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe <= 1'b0;
      o_serial_shift_reg <= '0;
      o_selected <= 1'b0;
      o_dir_read <= 1'b0;
      o_ext_code <= 1'b0;
      o_transfer_done_irq <= 1'b0;
      o_mst_busy <= 1'b0;
      o_mst_acked <= 1'b0;
    end else begin
      o_sda_oe <= nxt_sda_oe;
      o_scl_oe <= nxt_scl_oe;
      o_mst_busy <= mst_active;
      o_mst_acked <= acked_ff;
      o_selected <= slv_busy_s & slv_stat.selected;
      if (slv_hit) begin
        o_serial_shift_reg <= slv_rx_byte;
        o_dir_read <= slv_stat.dir;
        o_ext_code <= slv_stat.ext;
      end else if (st_ff == M_IDLE && nxt_st == M_START) begin
        o_serial_shift_reg <= load_byte;
      end
      // pulse on own address, extension code or master address send done
      o_transfer_done_irq <= slv_hit || st_ff == M_DONE;
    end
  end
endmodule
`default_nettype wire

// >>> tb/iar_checker.sv
// assertion checker for the address recognition top
`timescale 1ns/1ps
`default_nettype none
module iar_checker
  import iar_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_sda,
  input wire logic i_scl,
  input wire logic [ADDR_W-1:0] i_own_slave_address_reg,
  input wire logic i_send_req,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic [BYTE_W-1:0] o_serial_shift_reg,
  input wire logic o_selected,
  input wire logic o_dir_read,
  input wire logic o_ext_code,
  input wire logic o_transfer_done_irq,
  input wire logic o_mst_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] low_ff;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) low_ff <= 16'h0000;
    else low_ff <= o_scl_oe ? low_ff + 16'h0001 : 16'h0000;
  end
  // five high samples rule out aliasing of the fast link clock
  sequence stop_seen;
    i_scl [*5] ##0 $rose(i_sda);
  endsequence
  sequence slave_hit;
    o_transfer_done_irq && !o_mst_busy && !$past(o_mst_busy);
  endsequence
  irq_pulse_a: assert property (o_transfer_done_irq |=> !o_transfer_done_irq)
    else $error("irq pulse too long");
  open_drain_a: assert property (!o_sda_out && !o_scl_out)
    else $error("line driven high");
  req_taken_a: assert property ($rose(o_mst_busy) |-> $past(i_send_req, 2))
    else $error("busy without request");
  scl_idle_a: assert property (!o_mst_busy |-> !o_scl_oe)
    else $error("scl held while idle");
  // low phase runs from timer zero up to the half count inclusive
  scl_low_a: assert property ($fell(o_scl_oe) && o_mst_busy |-> low_ff == SCL_HALF_CNT + 16'h0001)
    else $error("scl low phase length");
  sda_hold_a: assert property (o_mst_busy && !o_scl_oe && $past(!o_scl_oe) |-> !$fell(o_sda_oe))
    else $error("sda moved with scl high");
  stop_drop_a: assert property (stop_seen |-> ##[1:8] !o_selected)
    else $error("selected after stop");
  hit_cause_a: assert property (slave_hit |-> o_selected || o_ext_code)
    else $error("irq without match");
  addr_match_a: assert property (slave_hit and o_selected |-> o_serial_shift_reg[7:1] == i_own_slave_address_reg)
    else $error("selected on wrong address");
  dir_bit_a: assert property (slave_hit |-> o_dir_read == o_serial_shift_reg[0])
    else $error("direction mismatch");
endmodule
bind iar_top iar_checker u_iar_checker (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_sda(i_sda), .i_scl(i_scl),
  .i_own_slave_address_reg(i_own_slave_address_reg), .i_send_req(i_send_req), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_serial_shift_reg(o_serial_shift_reg),
  .o_selected(o_selected), .o_dir_read(o_dir_read), .o_ext_code(o_ext_code),
  .o_transfer_done_irq(o_transfer_done_irq), .o_mst_busy(o_mst_busy));
`default_nettype wire

// >>> tb/iar_bus_model.sv
// far-side bus party: master frames, acknowledge and stop
`timescale 1ns/1ps
`default_nettype none
module iar_bus_model (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_rel,
  output logic o_sda_pull
);
  initial begin
    o_scl_rel = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic frame(input logic [7:0] b, input logic stp, output logic ack);
    o_sda_pull = 1'b1;
    #20 o_scl_rel = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #2 o_sda_pull = ~b[i];
      #4 o_scl_rel = 1'b1;
      #6 o_scl_rel = 1'b0;
    end
    // long ack low phases: the slave's ack passes a ref-clock output flop
    #2 o_sda_pull = 1'b0;
    #20 o_scl_rel = 1'b1;
    #3 ack = i_sda;
    #3 o_scl_rel = 1'b0;
    #20 o_sda_pull = stp;
    #4 o_scl_rel = 1'b1;
    // clock stands still between frames
    #60 o_sda_pull = 1'b0;
    #20;
  endtask
  task automatic ack_master(input logic nak);
    repeat (8) @(posedge i_scl);
    @(negedge i_scl) o_sda_pull = !nak;
    @(negedge i_scl) o_sda_pull = 1'b0;
  endtask
  task automatic stop_only();
    o_scl_rel = 1'b0;
    #6 o_sda_pull = 1'b1;
    #6 o_scl_rel = 1'b1;
    #60 o_sda_pull = 1'b0;
    #20;
  endtask
endmodule
`default_nettype wire

// >>> tb/iar_tb_top.sv
// testbench top for the address recognition block
`timescale 1ns/1ps
`default_nettype none
module iar_tb_top;
  import iar_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, req = 1'b0, dir = 1'b0;
  logic [ADDR_W-1:0] own = 7'h5a, saddr = 7'h00;
  logic sda_oe, scl_oe, scl_rel, sda_pull, ack, sel, dr, ext, irq, busy, acked;
  logic [BYTE_W-1:0] sr;
  logic [8:0] wire_sr = 9'h000;
  int irq_n = 0, fail_count = 0, compares = 0;
  wire logic sda_w = !(sda_oe | sda_pull);
  wire logic scl_w = !scl_oe & scl_rel;
  iar_top u_iar_top (.i_ref_clk(clk), .i_arst_n(arst_n), .i_scl_link_clk(scl_w), .i_sda(sda_w), .i_scl(scl_w),
    .i_own_slave_address_reg(own), .i_send_req(req), .i_send_addr(saddr), .i_send_dir(dir), .o_sda_out(),
    .o_sda_oe(sda_oe), .o_scl_out(), .o_scl_oe(scl_oe), .o_serial_shift_reg(sr), .o_selected(sel),
    .o_dir_read(dr), .o_ext_code(ext), .o_transfer_done_irq(irq), .o_mst_busy(busy), .o_mst_acked(acked));
  iar_bus_model u_iar_bus_model (.i_scl(scl_w), .i_sda(sda_w), .o_scl_rel(scl_rel), .o_sda_pull(sda_pull));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
  always @(posedge scl_w) wire_sr <= {wire_sr[7:0], sda_w};
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic slv(input logic [7:0] b, input logic stp);
    u_iar_bus_model.frame(b, stp, ack);
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic t_match(input logic d);
    int n0;
    n0 = irq_n;
    slv({own, d}, 1'b0);
    chk(9'(irq_n - n0), 9'h001);
    chk({sr, ack}, {own, d, 1'b0});
    chk({6'h00, sel, dr, ext}, {6'h00, 1'b1, d, 1'b0});
    n0 = irq_n;
    slv({own ^ 7'h01, d}, 1'b1);
    chk({7'h00, sel, ack}, 9'h001);
    chk(9'(irq_n - n0), 9'h000);
    $display("match test done");
  endtask
  task automatic t_ext();
    int n0;
    n0 = irq_n;
    slv({own, DIR_WRITE}, 1'b0);
    slv(8'hf1, 1'b1);
    chk(9'(irq_n - n0), 9'h002);
    chk({sr, ext}, 9'h1e3);
    chk({8'h00, sel}, 9'h000);
    $display("extension test done");
  endtask
  task automatic t_master(input logic d, input logic nak);
    int n0;
    logic [8:0] exp;
    n0 = irq_n;
    exp = {7'h33, d, nak};
    fork
      u_iar_bus_model.ack_master(nak);
    join_none
    saddr = 7'h33;
    dir = d;
    req = 1'b1;
    @(posedge clk) #1 req = 1'b0;
    repeat (100) @(posedge clk);
    // a request while busy must not disturb the byte on the wire
    #1 saddr = 7'h0f;
    req = 1'b1;
    @(posedge clk) #1 req = 1'b0;
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    chk(wire_sr, exp);
    chk({sr, acked}, {7'h33, d, !nak});
    chk(9'(irq_n - n0), 9'h001);
    u_iar_bus_model.stop_only();
    repeat (10) @(posedge clk);
    #1;
    $display("master test done");
  endtask
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_match(DIR_READ);
    t_match(DIR_WRITE);
    t_ext();
    t_master(DIR_WRITE, 1'b0);
    t_master(DIR_READ, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
